/* fawp_pkg.sv */
// constants and carriers for the flash access and write protection block
// assumes a single 40 MHz clock and synchronous active-high reset
// What this block does
// RULE_01: disable fuse x at 0 with reenable fuse x at 1 bypasses access protect
// RULE_02: disable fuse 0 programmable only after debug and access fuses are 0
// RULE_03: disable fuse x programmable only after reenable fuse x-1 is 0
// RULE_04: reenable fuse x at 0 with disable fuse x+1 at 1 reapplies protection
// RULE_05: reenable fuse x programmable only after disable fuse x is 0
// RULE_06: sixteen disable and reenable fuse pairs exist
// RULE_07: temporary unprotect bit at 1 suspends access protection
// RULE_08: temporary unprotect bit set only by writes fetched from flash
// RULE_09: protected flash data reads allowed only for flash fetched code
// RULE_10: protected flash data writes from ram or external code are discarded
// RULE_11: protected flash read from outside returns dummy data and trap 0x009b
// RULE_12: protected flash blocks peripheral event transfer data accesses
// RULE_13: protected flash blocks control register writes, reads stay allowed
// RULE_14: sectors with write protect fuse at 0 cannot be programmed or erased
// RULE_15: set protection writing 1 to sector bits lifts their protection
// RULE_16: reset or set protection writing 0 restores sector write protection
// RULE_17: temporary unprotection touches only the volatile copy, not the fuses
// RULE_18: reset or clearing temporary unprotect bit restores access protection
// RULE_19: software enables protection via unprotect, fuse program, then clear
// RULE_20: reset forces all protection active, then loads fuses into copies
// RULE_21: set protection launched from flash fetched code is refused
// RULE_22: bypass is the or over all sixteen per-index disable conditions
`default_nettype none
package fawp_pkg;
    localparam int FAWP_PAIRS = 16;
    localparam int FAWP_SECTORS = 10;
    localparam logic [19:0] FAWP_OFS_REENABLE = 20'h8_dfbe;
    localparam logic [19:0] FAWP_OFS_DISABLE = 20'h8_dfbc;
    localparam logic [19:0] FAWP_OFS_APR0 = 20'h8_dfb8;
    localparam logic [19:0] FAWP_OFS_WPIR = 20'h8_dfb4;
    localparam logic [19:0] FAWP_OFS_TEMP = 20'h8_dfb0;
    localparam logic [15:0] FAWP_RST_REENABLE = 16'hffff;
    localparam logic [15:0] FAWP_RST_DISABLE = 16'hffff;
    localparam logic [15:0] FAWP_RST_WPIR = 16'h0000;
    localparam int FAWP_BIT_ACCESS_PROTECT_FUSE = 0;
    localparam int FAWP_BIT_DEBUG_PROTECT_FUSE = 1;
    localparam int FAWP_BIT_TEMP_UNPROTECT_BIT = 0;
    localparam logic [15:0] FAWP_TRAP_NUM = 16'h009b;
    localparam logic [15:0] FAWP_DUMMY_DATA = 16'h0000;

    typedef enum logic [1:0] {
        FAWP_SRC_FLASH,
        FAWP_SRC_INTERNAL_RAM,
        FAWP_SRC_EXTENSION_RAM,
        FAWP_SRC_EXT
    } fawp_src_t;

    typedef struct packed {
        logic [15:0] reenable;
        logic [15:0] disable_f;
        logic [15:0] wpir;
        logic access_protect_fuse;
        logic debug_protect_fuse;
    } fawp_fuse_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic peripheral_event_transfer;
        fawp_src_t src;
        logic [19:0] addr;
        logic [15:0] wdata;
    } fawp_req_t;
endpackage : fawp_pkg
`default_nettype wire

/* fawp_bypass.sv */
// per-index fuse pair decode into an access protect bypass
// assumes fuse vectors are the volatile copies
`default_nettype none
module fawp_bypass
    import fawp_pkg::*;
(
    input wire logic [15:0] disable_in,
    input wire logic [15:0] reenable_in,
    output logic bypass_out
);
    always_comb begin
        bypass_out = 1'b0;
        for (int i = 0; i < FAWP_PAIRS; i++) begin
            // a reenabled pair (rule 4) drops its own term; next pair governs
            bypass_out = bypass_out | (~disable_in[i] & reenable_in[i]); // RULE_01 RULE_04 RULE_22
        end
    end
endmodule : fawp_bypass
`default_nettype wire

/* fawp_top.sv */
// flash access and write protection logic with volatile fuse copies
// assumes fuses are presented at reset and requests are synchronous to clk
`default_nettype none
module fawp_top
    import fawp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire fawp_fuse_t nv_fuse_in,
    input wire fawp_req_t req_in,
    input wire logic [15:0] flash_rdata_in,
    input wire logic setprot_in,
    input wire fawp_src_t setprot_src_in,
    input wire logic [19:0] setprot_addr_in,
    input wire logic [15:0] setprot_data_in,
    input wire logic [FAWP_SECTORS-1:0] pe_sector_in,
    input wire logic pe_start_in,
    output logic [15:0] rdata_out,
    output logic rvalid_out,
    output logic trap_out,
    output logic [15:0] trap_num_out,
    output logic flash_wr_en_out,
    output logic pec_block_out,
    output logic ctrl_wr_en_out,
    output logic [FAWP_SECTORS-1:0] pe_allow_out,
    output logic setprot_done_out,
    output logic setprot_refused_out,
    output logic access_protected_out
);
    typedef struct packed {
        logic loaded;
        logic [15:0] disable_f;
        logic [15:0] reenable;
        logic [15:0] nv_disable;
        logic [15:0] nv_reenable;
        logic [15:0] wp_vol;
        logic [15:0] nv_wpir;
        logic access_protect_fuse;
        logic debug_protect_fuse;
        logic temp_unprotect_bit;
        logic [15:0] rdata;
        logic rvalid;
        logic trap;
        logic wr_en;
        logic pec_block;
        logic ctrl_wr;
        logic [FAWP_SECTORS-1:0] pe_allow;
        logic sp_done;
        logic sp_ref;
    } fawp_state_t;

    fawp_state_t st_ff;
    fawp_state_t nxt_st;
    logic bypass;
    logic prot;
    logic from_flash;
    logic ctrl_hit;
    logic flash_hit;

    function automatic logic is_flash_addr(input logic [19:0] a);
        return a < FAWP_OFS_TEMP;
    endfunction : is_flash_addr

    fawp_bypass u_bypass (
        .disable_in(st_ff.disable_f),
        .reenable_in(st_ff.reenable),
        .bypass_out(bypass)
    );

    assign from_flash = (req_in.src == FAWP_SRC_FLASH);
    assign prot = st_ff.access_protect_fuse == 1'b0 && !bypass && !st_ff.temp_unprotect_bit; // RULE_07 RULE_09
    assign ctrl_hit = !is_flash_addr(req_in.addr);
    assign flash_hit = is_flash_addr(req_in.addr);

    always_comb begin
        logic [15:0] d;
        d = 16'h0000;
        nxt_st = st_ff;
        nxt_st.rvalid = 1'b0;
        nxt_st.trap = 1'b0;
        nxt_st.wr_en = 1'b0;
        nxt_st.ctrl_wr = 1'b0;
        nxt_st.sp_done = 1'b0;
        nxt_st.sp_ref = 1'b0;
        nxt_st.pec_block = 1'b0;
        nxt_st.pe_allow = '0;
        if (!st_ff.loaded) begin
            // protections stay forced while copies are still empty
            nxt_st.loaded = 1'b1; // RULE_20
            nxt_st.disable_f = nv_fuse_in.disable_f;
            nxt_st.reenable = nv_fuse_in.reenable;
            nxt_st.nv_disable = nv_fuse_in.disable_f;
            nxt_st.nv_reenable = nv_fuse_in.reenable;
            nxt_st.wp_vol = nv_fuse_in.wpir;
            nxt_st.nv_wpir = nv_fuse_in.wpir;
            nxt_st.access_protect_fuse = nv_fuse_in.access_protect_fuse;
            nxt_st.debug_protect_fuse = nv_fuse_in.debug_protect_fuse;
        end else begin
            if (req_in.valid) begin
                if (flash_hit) begin
                    if (req_in.peripheral_event_transfer && prot) begin
                        nxt_st.pec_block = 1'b1; // RULE_12
                    end else if (!req_in.write) begin
                        nxt_st.rvalid = 1'b1;
                        if (prot && !from_flash) begin
                            nxt_st.rdata = FAWP_DUMMY_DATA; // RULE_11
                            nxt_st.trap = 1'b1; // RULE_11
                        end else begin
                            nxt_st.rdata = flash_rdata_in; // RULE_09
                        end
                    end else begin
                        nxt_st.wr_en = !(prot && !from_flash); // RULE_10
                    end
                end else if (ctrl_hit && req_in.write) begin
                    nxt_st.ctrl_wr = !prot && req_in.addr != FAWP_OFS_TEMP; // RULE_13
                    if (req_in.addr == FAWP_OFS_TEMP) begin
                        if (!req_in.wdata[FAWP_BIT_TEMP_UNPROTECT_BIT]) begin
                            nxt_st.temp_unprotect_bit = 1'b0; // RULE_18
                        end else if (from_flash) begin
                            nxt_st.temp_unprotect_bit = 1'b1; // RULE_08
                        end
                    end
                end else begin
                    nxt_st.rvalid = 1'b1;
                    case (req_in.addr)
                        FAWP_OFS_REENABLE: d = st_ff.nv_reenable;
                        FAWP_OFS_DISABLE: d = st_ff.nv_disable;
                        FAWP_OFS_WPIR: d = st_ff.nv_wpir; // RULE_17
                        FAWP_OFS_APR0: d = {14'h0000, st_ff.debug_protect_fuse, st_ff.access_protect_fuse};
                        FAWP_OFS_TEMP: d = {15'h0000, st_ff.temp_unprotect_bit};
                        default: d = 16'h0000;
                    endcase
                    nxt_st.rdata = d; // RULE_13
                end
            end
            if (pe_start_in) begin
                nxt_st.pe_allow = pe_sector_in & st_ff.wp_vol[FAWP_SECTORS-1:0]; // RULE_14
            end
            if (setprot_in) begin
                if (setprot_src_in == FAWP_SRC_FLASH || prot) begin
                    nxt_st.sp_ref = 1'b1; // RULE_21
                end else begin
                    nxt_st.sp_done = 1'b1;
                    case (setprot_addr_in)
                        FAWP_OFS_WPIR: begin
                            // volatile copy follows data; fuse only clears
                            nxt_st.wp_vol = setprot_data_in; // RULE_15 RULE_16 RULE_17
                            nxt_st.nv_wpir = st_ff.nv_wpir & setprot_data_in;
                        end
                        FAWP_OFS_APR0: begin
                            nxt_st.nv_disable = st_ff.nv_disable;
                            if (!setprot_data_in[FAWP_BIT_ACCESS_PROTECT_FUSE]) begin
                                nxt_st.access_protect_fuse = 1'b0;
                            end
                            if (!setprot_data_in[FAWP_BIT_DEBUG_PROTECT_FUSE]) begin
                                nxt_st.debug_protect_fuse = 1'b0;
                            end
                        end
                        FAWP_OFS_DISABLE: begin
                            for (int i = 0; i < FAWP_PAIRS; i++) begin // RULE_06
                                if (!setprot_data_in[i]) begin
                                    if (i == 0) begin
                                        if (!st_ff.debug_protect_fuse && !st_ff.access_protect_fuse) begin
                                            nxt_st.nv_disable[i] = 1'b0; // RULE_02
                                        end
                                    end else if (!st_ff.nv_reenable[i-1]) begin
                                        nxt_st.nv_disable[i] = 1'b0; // RULE_03
                                    end
                                end
                            end
                            nxt_st.disable_f = nxt_st.nv_disable;
                        end
                        FAWP_OFS_REENABLE: begin
                            for (int i = 0; i < FAWP_PAIRS; i++) begin
                                if (!setprot_data_in[i] && !st_ff.nv_disable[i]) begin
                                    nxt_st.nv_reenable[i] = 1'b0; // RULE_05
                                end
                            end
                            nxt_st.reenable = nxt_st.nv_reenable;
                        end
                        default: nxt_st.sp_ref = 1'b0;
                    endcase
                end
            end
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            // all protections forced active until the fuses are loaded
            st_ff <= '0; // RULE_20 RULE_16 RULE_18
            st_ff.disable_f <= FAWP_RST_DISABLE;
            st_ff.reenable <= FAWP_RST_REENABLE;
            st_ff.nv_disable <= FAWP_RST_DISABLE;
            st_ff.nv_reenable <= FAWP_RST_REENABLE;
            st_ff.wp_vol <= FAWP_RST_WPIR;
            st_ff.nv_wpir <= FAWP_RST_WPIR;
            st_ff.rdata <= 16'h0000;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign rdata_out = st_ff.rdata;
    assign rvalid_out = st_ff.rvalid;
    assign trap_out = st_ff.trap;
    assign trap_num_out = FAWP_TRAP_NUM;
    assign flash_wr_en_out = st_ff.wr_en;
    assign pec_block_out = st_ff.pec_block;
    assign ctrl_wr_en_out = st_ff.ctrl_wr;
    assign pe_allow_out = st_ff.pe_allow;
    assign setprot_done_out = st_ff.sp_done;
    assign setprot_refused_out = st_ff.sp_ref;
    assign access_protected_out = prot | !st_ff.loaded;
endmodule : fawp_top
`default_nettype wire

/* fawp_flash_model.sv */
// flash array data source facing the protection block
// assumes req_in carries the access that the cpu or pec issues
`default_nettype none
module fawp_flash_model
    import fawp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire fawp_req_t req_in,
    output logic [15:0] flash_rdata_out
);
    logic [15:0] churn_ff = 16'h1234;
    // idle data wanders so stale data never looks valid
    always_ff @(posedge clk_sys_in) begin
        churn_ff <= churn_ff + 16'h3c5d;
    end
    assign flash_rdata_out = req_in.valid ? (req_in.addr[15:0] ^ 16'h5a5a) : churn_ff;
endmodule : fawp_flash_model
`default_nettype wire

/* fawp_top_props.sv */
// port assertions for the protection block
// assumes one clock domain, bound to fawp_top
`default_nettype none
module fawp_top_props
    import fawp_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire fawp_fuse_t nv_fuse_in,
    input wire fawp_req_t req_in,
    input wire logic [15:0] flash_rdata_in,
    input wire logic setprot_in,
    input wire fawp_src_t setprot_src_in,
    input wire logic [19:0] setprot_addr_in,
    input wire logic [15:0] setprot_data_in,
    input wire logic [FAWP_SECTORS-1:0] pe_sector_in,
    input wire logic pe_start_in,
    input wire logic [15:0] rdata_out,
    input wire logic rvalid_out,
    input wire logic trap_out,
    input wire logic [15:0] trap_num_out,
    input wire logic flash_wr_en_out,
    input wire logic pec_block_out,
    input wire logic ctrl_wr_en_out,
    input wire logic [FAWP_SECTORS-1:0] pe_allow_out,
    input wire logic setprot_done_out,
    input wire logic setprot_refused_out,
    input wire logic access_protected_out
);
    default clocking cb @(posedge clk_sys_in); endclocking
    default disable iff (rst_in);
    logic arr_rd;
    logic prot_wr;
    assign arr_rd = req_in.valid && !req_in.write && !req_in.peripheral_event_transfer && req_in.addr < FAWP_OFS_TEMP;
    assign prot_wr = req_in.valid && req_in.write && access_protected_out;
    sequence s_outside_read;
        arr_rd && req_in.src != FAWP_SRC_FLASH && access_protected_out;
    endsequence
    a_reset_protect: assert property (disable iff (1'b0) rst_in |=> access_protected_out)
        else $error("protection not forced in reset");
    a_outside_trap: assert property (s_outside_read |=> trap_out && rvalid_out && rdata_out == 16'h0000)
        else $error("outside read not trapped");
    a_trap_number: assert property (trap_out |-> trap_num_out == 16'h009b)
        else $error("trap number wrong");
    a_flash_read: assert property (arr_rd && req_in.src == FAWP_SRC_FLASH |=> !trap_out && rdata_out == $past(flash_rdata_in))
        else $error("flash fetched read wrong");
    a_write_drop: assert property (prot_wr && req_in.src != FAWP_SRC_FLASH && req_in.addr < FAWP_OFS_TEMP |=> !flash_wr_en_out)
        else $error("protected write passed");
    a_pec_block: assert property (req_in.valid && req_in.peripheral_event_transfer && req_in.addr < FAWP_OFS_TEMP && access_protected_out |=> pec_block_out)
        else $error("pec access not blocked");
    a_ctrl_block: assert property (prot_wr && req_in.addr > FAWP_OFS_TEMP && req_in.addr <= FAWP_OFS_REENABLE |=> !ctrl_wr_en_out)
        else $error("control write passed");
    a_setprot_flash: assert property (setprot_in && setprot_src_in == FAWP_SRC_FLASH |=> setprot_refused_out && !setprot_done_out)
        else $error("setprot from flash accepted");
    a_temp_unprotect_bit_ignored: assert property (prot_wr && req_in.addr == FAWP_OFS_TEMP && req_in.src != FAWP_SRC_FLASH |=> access_protected_out)
        else $error("unprotect from outside flash");
    a_pe_subset: assert property (pe_start_in |=> (pe_allow_out & ~$past(pe_sector_in)) == '0)
        else $error("unrequested sector allowed");
endmodule : fawp_top_props
bind fawp_top fawp_top_props u_props (.clk_sys_in, .rst_in, .nv_fuse_in, .req_in, .flash_rdata_in,
    .setprot_in, .setprot_src_in, .setprot_addr_in, .setprot_data_in, .pe_sector_in, .pe_start_in,
    .rdata_out, .rvalid_out, .trap_out, .trap_num_out, .flash_wr_en_out, .pec_block_out,
    .ctrl_wr_en_out, .pe_allow_out, .setprot_done_out, .setprot_refused_out, .access_protected_out);
`default_nettype wire

/* tb_fawp_top.sv */
// self-checking bench for the protection block
// assumes block, flash model and checker are compiled first
`default_nettype none
module tb_fawp_top
    import fawp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_in, rst_in, sp, pe_go, rvalid, trap, wr_en, pec_blk, ctrl_en, sp_done, sp_ref, prot;
    fawp_fuse_t nv;
    fawp_req_t req;
    fawp_src_t sp_src;
    logic [19:0] sp_addr;
    logic [15:0] frd, sp_data, rdata, tnum;
    logic [FAWP_SECTORS-1:0] pe_sec, pe_ok;
    int error_cnt = 0, total_checks = 0, cyc = 0;
    logic [15:0] t_ds [4] = '{16'hfffc, 16'hfffc, 16'h7fff, 16'hfffe};
    logic [15:0] t_re [4] = '{16'hfffe, 16'hfffc, 16'hffff, 16'hfffe};
    logic t_pr [4] = '{1'b0, 1'b1, 1'b0, 1'b1};
    fawp_top u_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .nv_fuse_in(nv), .req_in(req),
        .flash_rdata_in(frd), .setprot_in(sp), .setprot_src_in(sp_src), .setprot_addr_in(sp_addr),
        .setprot_data_in(sp_data), .pe_sector_in(pe_sec), .pe_start_in(pe_go), .rdata_out(rdata),
        .rvalid_out(rvalid), .trap_out(trap), .trap_num_out(tnum), .flash_wr_en_out(wr_en),
        .pec_block_out(pec_blk), .ctrl_wr_en_out(ctrl_en), .pe_allow_out(pe_ok),
        .setprot_done_out(sp_done), .setprot_refused_out(sp_ref), .access_protected_out(prot));
    fawp_flash_model u_flash (.clk_sys_in(clk_sys_in), .req_in(req), .flash_rdata_out(frd));
    initial begin
        clk_sys_in = 1'b0;
        forever #12.5 clk_sys_in = ~clk_sys_in;
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task go(input fawp_src_t s, input logic w, input logic p, input logic [19:0] a,
            input logic [15:0] d);
        @(posedge clk_sys_in);
        req <= '{1'b1, w, p, s, a, d};
        @(posedge clk_sys_in);
        req.valid <= 1'b0;
        #1;
    endtask : go
    task setp(input fawp_src_t s, input logic [19:0] a, input logic [15:0] d);
        @(posedge clk_sys_in);
        sp <= 1'b1;
        sp_src <= s;
        sp_addr <= a;
        sp_data <= d;
        @(posedge clk_sys_in);
        sp <= 1'b0;
        #1;
    endtask : setp
    task pe(input logic [FAWP_SECTORS-1:0] sec);
        @(posedge clk_sys_in);
        pe_sec <= sec;
        pe_go <= 1'b1;
        @(posedge clk_sys_in);
        pe_go <= 1'b0;
        #1;
    endtask : pe
    task rst(input logic [15:0] ds, input logic [15:0] re);
        @(posedge clk_sys_in);
        nv <= '{re, ds, 16'h03f0, 1'b0, 1'b0};
        rst_in <= 1'b1;
        repeat (12) @(posedge clk_sys_in);
        rst_in <= 1'b0;
        #1 chk(prot, 1);
        repeat (2) @(posedge clk_sys_in);
        #1;
    endtask : rst
    task summarize;
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    always @(posedge clk_sys_in) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            error_cnt++;
            summarize();
        end
    end
    initial begin
        rst_in = 1'b1;
        nv = '0;
        req = '0;
        sp = 1'b0;
        sp_src = FAWP_SRC_INTERNAL_RAM;
        sp_addr = '0;
        sp_data = '0;
        pe_sec = '0;
        pe_go = 1'b0;
        rst(16'hffff, 16'hffff);
        chk(prot, 1);
        go(FAWP_SRC_FLASH, 0, 0, 20'h0_1234, 0);
        chk(rdata, 16'h1234 ^ 16'h5a5a);
        go(FAWP_SRC_INTERNAL_RAM, 0, 0, 20'h0_1234, 0);
        chk(trap, 1);
        chk(rdata, 16'h0000);
        chk(tnum, 16'h009b);
        go(FAWP_SRC_EXTENSION_RAM, 1, 0, 20'h0_2000, 16'h5555);
        chk(wr_en, 0);
        go(FAWP_SRC_EXT, 0, 1, 20'h0_2000, 0);
        chk(pec_blk, 1);
        go(FAWP_SRC_FLASH, 1, 0, FAWP_OFS_DISABLE, 16'hfffe);
        chk(ctrl_en, 0);
        go(FAWP_SRC_INTERNAL_RAM, 0, 0, FAWP_OFS_REENABLE, 0);
        chk(rvalid, 1);
        chk(rdata, 16'hffff);
        go(FAWP_SRC_INTERNAL_RAM, 1, 0, FAWP_OFS_TEMP, 16'h0001);
        chk(prot, 1);
        go(FAWP_SRC_FLASH, 1, 0, FAWP_OFS_TEMP, 16'h0001);
        chk(prot, 0);
        go(FAWP_SRC_EXTENSION_RAM, 0, 0, 20'h0_0100, 0);
        chk(trap, 0);
        chk(rdata, 16'h0100 ^ 16'h5a5a);
        setp(FAWP_SRC_FLASH, FAWP_OFS_WPIR, 16'h03ff);
        chk(sp_ref, 1);
        pe(10'h3ff);
        chk(pe_ok, 10'h3f0);
        // unprotect, set protection, then clear: the recommended software order
        setp(FAWP_SRC_INTERNAL_RAM, FAWP_OFS_WPIR, 16'h03ff);
        chk(sp_done, 1);
        pe(10'h3ff);
        chk(pe_ok, 10'h3ff);
        go(FAWP_SRC_INTERNAL_RAM, 0, 0, FAWP_OFS_WPIR, 0);
        chk(rdata, 16'h03f0);
        setp(FAWP_SRC_EXT, FAWP_OFS_WPIR, 16'h03f0);
        pe(10'h3ff);
        chk(pe_ok, 10'h3f0);
        go(FAWP_SRC_EXT, 1, 0, FAWP_OFS_TEMP, 16'h0000);
        chk(prot, 1);
        $display("protected access test done");
        // unprotected writes pass, then fuse pair programming order
        rst(16'hffff, 16'hffff);
        go(FAWP_SRC_FLASH, 1, 0, FAWP_OFS_TEMP, 16'h0001);
        go(FAWP_SRC_INTERNAL_RAM, 1, 0, 20'h0_0200, 16'h1111);
        chk(wr_en, 1);
        go(FAWP_SRC_FLASH, 1, 0, FAWP_OFS_DISABLE, 16'hffff);
        chk(ctrl_en, 1);
        setp(FAWP_SRC_INTERNAL_RAM, FAWP_OFS_DISABLE, 16'hfffd);
        go(FAWP_SRC_INTERNAL_RAM, 0, 0, FAWP_OFS_DISABLE, 0);
        chk(rdata, 16'hffff);
        setp(FAWP_SRC_INTERNAL_RAM, FAWP_OFS_REENABLE, 16'hfffe);
        go(FAWP_SRC_INTERNAL_RAM, 0, 0, FAWP_OFS_REENABLE, 0);
        chk(rdata, 16'hffff);
        setp(FAWP_SRC_INTERNAL_RAM, FAWP_OFS_DISABLE, 16'hfffe);
        go(FAWP_SRC_INTERNAL_RAM, 0, 0, FAWP_OFS_DISABLE, 0);
        chk(rdata, 16'hfffe);
        go(FAWP_SRC_EXT, 1, 0, FAWP_OFS_TEMP, 16'h0000);
        chk(prot, 0);
        setp(FAWP_SRC_INTERNAL_RAM, FAWP_OFS_REENABLE, 16'hfffe);
        chk(prot, 1);
        go(FAWP_SRC_INTERNAL_RAM, 0, 0, FAWP_OFS_REENABLE, 0);
        chk(rdata, 16'hfffe);
        $display("fuse program test done");
        for (int i = 0; i < 4; i++) begin
            rst(t_ds[i], t_re[i]);
            chk(prot, t_pr[i]);
        end
        $display("fuse pair test done");
        summarize();
    end
endmodule : tb_fawp_top
`default_nettype wire
